/* File: logic/uas_top.sv */
`timescale 1ns/1ns
`include "uas_consts.svh"
// Contract
// - Full duplex, shared baud and format
// - Eight data bits, LSB first
// - One start bit, one or two stops
// - Parity generated on send, checked on receive
// - Parity sense selects even or odd
// - Detect framing, parity, overrun and break
// - Separate transmit and receive enables
// - Separate transmit and receive interrupts
// - Sixteen-bit divider times both directions
// - Divider doubles as sixteen-bit timer
// - Holding-empty flag reads one when free
// - Written byte moves to shifter automatically
// - Transmit interrupt while enabled and empty
// - Receive-ready flag shows valid byte held
// - Multidrop enable with four receive schemes
// - Flow enable lets clear-to-send hold transmission
// - Driver-enable output for bus transceiver
// - Clear-to-send checked before each new character
// - Address bit follows data, precedes stops
// - Driver enable high over whole frame
// - Schemes: all, addresses only, match, matched data
module uas_top
  import uas_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration
  input  wire logic        tx_enable,
  input  wire logic        rx_enable,
  input  wire logic        parity_on,
  input  wire logic        parity_odd,
  input  wire logic        two_stop,
  input  wire logic        flow_ctrl_en,
  input  wire logic        multidrop_on,
  input  wire logic [1:0]  multidrop_scheme,
  input  wire logic [7:0]  addr_compare,
  input  wire logic [15:0] baud_divider,
  input  wire logic        timer_mode,
  // Transmit data
  input  wire logic        tx_wr,
  input  wire logic [7:0]  tx_data,
  input  wire logic        addr_flag_tx,
  // Receive data
  input  wire logic        rx_rd,
  output logic      [7:0]  rx_data,
  output logic             rx_addr_flag,
  output logic             rx_new_frame,
  // Status and interrupts
  output logic             tx_holding_empty,
  output logic             rx_byte_ready,
  output logic             err_framing,
  output logic             err_parity,
  output logic             err_overrun,
  output logic             err_break,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             timer_tick,
  // Serial pins
  input  wire logic        rxd_pin,
  input  wire logic        cts_n_pin,
  output logic             txd,
  output logic             transceiver_drive
);

  uas_state_s q;
  uas_state_s n;
  logic       bit_en;
  logic       tx_go;
  logic       rx_done;
  logic       rx_acc;
  logic       rx_addr;
  logic       rx_match;
  logic       ninth_used;

  assign bit_en     = q.tick & ~timer_mode;
  assign ninth_used = parity_on | multidrop_on;
  assign tx_go      = bit_en & (q.tx_ph == UAS_IDLE) & tx_enable & q.hold_full
                      & ~(flow_ctrl_en & q.cts_s2);
  assign rx_done    = bit_en & (q.rx_ph == UAS_STOP) & (q.rx_cnt == `UAS_TICK_MID);
  assign rx_addr    = multidrop_on & q.rx_ninth;
  assign rx_match   = (q.rx_sh == addr_compare);

  always_comb begin
    rx_acc = 1'b1;
    if (multidrop_on) begin
      unique case (multidrop_scheme)
        `UAS_SCH_ALL:   rx_acc = 1'b1;
        `UAS_SCH_ADDR:  rx_acc = rx_addr;
        `UAS_SCH_MATCH: rx_acc = rx_addr ? rx_match : q.matched;
        `UAS_SCH_DATA:  rx_acc = ~rx_addr & q.matched;
      endcase
    end
  end

  always_comb begin
    n      = q;
    n.tick = 1'b0;
    n.rxd_s1 = rxd_pin;
    n.rxd_s2 = q.rxd_s1;
    n.cts_s1 = cts_n_pin;
    n.cts_s2 = q.cts_s1;
    if (tx_enable | rx_enable | timer_mode) begin
      if (q.div_cnt <= `UAS_DIV_ONE) begin
        n.div_cnt = baud_divider;
        n.tick    = 1'b1;
      end else begin
        n.div_cnt = q.div_cnt - `UAS_DIV_ONE;
      end
    end else begin
      n.div_cnt = baud_divider;
    end

    // Transmitter
    unique case (q.tx_ph)
      UAS_IDLE: begin
        n.txd = 1'b1;
        if (tx_go) begin
          n.tx_sh     = q.hold;
          n.hold_full = 1'b0;
          n.tx_ninth  = multidrop_on ? q.hold_flag : (^q.hold) ^ parity_odd;
          n.tx_ph     = UAS_START;
          n.tx_cnt    = 4'h0;
          n.txd       = 1'b0;
        end
      end
      default: begin
        if (bit_en) begin
          n.tx_cnt = q.tx_cnt + `UAS_TICK_ONE;
          if (q.tx_cnt == `UAS_TICK_LAST) begin
            unique case (q.tx_ph)
              UAS_START: begin
                n.tx_ph  = UAS_DATA;
                n.tx_bit = 3'h0;
                n.txd    = q.tx_sh[0];
              end
              UAS_DATA: begin
                if (q.tx_bit == `UAS_BIT_LAST) begin
                  n.tx_ph    = ninth_used ? UAS_NINTH : UAS_STOP;
                  n.txd      = ninth_used ? q.tx_ninth : 1'b1;
                  n.tx_stop2 = two_stop;
                end else begin
                  n.tx_bit = q.tx_bit + 3'h1;
                  n.tx_sh  = {1'b0, q.tx_sh[7:1]};
                  n.txd    = q.tx_sh[1];
                end
              end
              UAS_NINTH: begin
                n.tx_ph = UAS_STOP;
                n.txd   = 1'b1;
              end
              default: begin
                if (q.tx_stop2) begin
                  n.tx_stop2 = 1'b0;
                end else begin
                  n.tx_ph = UAS_IDLE;
                end
              end
            endcase
          end
        end
      end
    endcase
    // Write marks holding full, beats the move
    if (tx_wr) begin
      n.hold      = tx_data;
      n.hold_flag = addr_flag_tx;
      n.hold_full = 1'b1;
    end

    if (rx_rd) begin
      n.rx_ready  = 1'b0;
      n.err_fr    = 1'b0;
      n.err_par   = 1'b0;
      n.err_ovr   = 1'b0;
      n.err_brk   = 1'b0;
      n.new_frame = 1'b0;
    end

    // Receiver
    if (bit_en && q.rx_ph != UAS_IDLE && q.rx_cnt != `UAS_TICK_LAST) begin
      n.rx_cnt = q.rx_cnt + `UAS_TICK_ONE;
    end
    unique case (q.rx_ph)
      UAS_IDLE: begin
        if (bit_en && !q.rxd_s2) begin
          n.rx_ph  = UAS_START;
          n.rx_cnt = `UAS_TICK_ONE;
        end
      end
      UAS_START: begin
        if (bit_en && q.rx_cnt == `UAS_TICK_MID && q.rxd_s2) begin
          n.rx_ph = UAS_IDLE;
        end else if (bit_en && q.rx_cnt == `UAS_TICK_LAST) begin
          n.rx_ph  = UAS_DATA;
          n.rx_cnt = 4'h0;
          n.rx_bit = 3'h0;
        end
      end
      UAS_DATA: begin
        if (bit_en && q.rx_cnt == `UAS_TICK_MID) begin
          n.rx_sh = {q.rxd_s2, q.rx_sh[7:1]};
        end
        if (bit_en && q.rx_cnt == `UAS_TICK_LAST) begin
          n.rx_cnt = 4'h0;
          n.rx_bit = q.rx_bit + 3'h1;
          if (q.rx_bit == `UAS_BIT_LAST) begin
            n.rx_ph = ninth_used ? UAS_NINTH : UAS_STOP;
          end
        end
      end
      UAS_NINTH: begin
        if (bit_en && q.rx_cnt == `UAS_TICK_MID) begin
          n.rx_ninth = q.rxd_s2;
        end
        if (bit_en && q.rx_cnt == `UAS_TICK_LAST) begin
          n.rx_cnt = 4'h0;
          n.rx_ph  = UAS_STOP;
        end
      end
      default: begin
        // Wait for idle line after the stop sample
        if (q.rx_cnt > `UAS_TICK_MID && q.rxd_s2) begin
          n.rx_ph = UAS_IDLE;
        end
      end
    endcase
    if (rx_done) begin
      n.rx_cnt = `UAS_TICK_LAST;
      if (!q.rxd_s2) begin
        if (q.rx_sh == `UAS_BYTE_RST && !(ninth_used && q.rx_ninth)) begin
          n.err_brk = 1'b1;
        end else begin
          n.err_fr = 1'b1;
        end
      end
      if (parity_on && !multidrop_on && ((^q.rx_sh) ^ parity_odd) != q.rx_ninth) begin
        n.err_par = 1'b1;
      end
      if (multidrop_on && rx_addr) begin
        n.matched    = rx_match;
        n.first_data = rx_match;
      end
      if (rx_acc) begin
        if (q.rx_ready && !rx_rd) begin
          n.err_ovr = 1'b1;
        end else begin
          n.rx_data   = q.rx_sh;
          n.rx_flag   = rx_addr;
          n.rx_ready  = 1'b1;
          n.new_frame = ~rx_addr & q.first_data & multidrop_scheme[1];
          if (!rx_addr) begin
            n.first_data = 1'b0;
          end
        end
      end
    end
    if (!rx_enable) begin
      n.rx_ph = UAS_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q           <= '0;
      q.rxd_s1    <= 1'b1;
      q.rxd_s2    <= 1'b1;
      q.cts_s1    <= 1'b1;
      q.cts_s2    <= 1'b1;
      q.txd       <= 1'b1;
      q.tx_ph     <= UAS_IDLE;
      q.rx_ph     <= UAS_IDLE;
    end else begin
      q <= n;
    end
  end

  assign rx_data           = q.rx_data;
  assign rx_addr_flag      = q.rx_flag;
  assign rx_new_frame      = q.new_frame;
  assign tx_holding_empty  = ~q.hold_full;
  assign rx_byte_ready     = q.rx_ready;
  assign err_framing       = q.err_fr;
  assign err_parity        = q.err_par;
  assign err_overrun       = q.err_ovr;
  assign err_break         = q.err_brk;
  assign tx_irq            = tx_enable & ~q.hold_full;
  assign rx_irq            = rx_enable & (q.rx_ready | q.err_fr | q.err_par
                             | q.err_ovr | q.err_brk);
  assign timer_tick        = q.tick;
  assign txd               = q.txd;
  assign transceiver_drive = (q.tx_ph != UAS_IDLE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_tx_load;
    tx_go && !tx_wr;
  endsequence
  sequence s_rx_late;
    rx_done && rx_acc && q.rx_ready && !rx_rd;
  endsequence

  AST_HOLD_CLEAR: assert property (tx_wr |=> !tx_holding_empty)
    else $error("holding flag not cleared by write");
  AST_LOAD_START: assert property (s_tx_load |=> q.tx_ph == UAS_START && !txd
    && tx_holding_empty)
    else $error("byte not moved to shifter");
  AST_LSB_FIRST: assert property ((q.tx_ph == UAS_START && bit_en
    && q.tx_cnt == `UAS_TICK_LAST) |=> txd == $past(q.tx_sh[0]))
    else $error("first data bit is not the lsb");
  AST_STOP_HIGH: assert property (q.tx_ph == UAS_STOP |-> txd)
    else $error("stop bit low");
  AST_DRIVE: assert property (s_tx_load |=> transceiver_drive [*8])
    else $error("driver enable dropped in frame");
  AST_CTS_HOLD: assert property ((flow_ctrl_en && q.cts_s2 && q.tx_ph == UAS_IDLE)
    |=> q.tx_ph == UAS_IDLE)
    else $error("started while clear-to-send off");
  AST_TX_IRQ: assert property ((tx_enable && tx_holding_empty) |-> tx_irq)
    else $error("transmit interrupt missing");
  AST_RD_CLEAR: assert property ((rx_rd && !rx_done) |=> !rx_byte_ready)
    else $error("read did not clear ready");
  AST_OVERRUN: assert property (s_rx_late |=> err_overrun && rx_irq)
    else $error("overrun not flagged");

endmodule : uas_top

/* File: logic/uas_consts.svh */
`ifndef UAS_CONSTS_SVH
`define UAS_CONSTS_SVH
// Oversampling: sixteen divider ticks per bit
`define UAS_TICK_LAST 4'hf
`define UAS_TICK_MID  4'h7
`define UAS_TICK_ONE  4'h1
`define UAS_BIT_LAST  3'h7
`define UAS_DIV_ONE   16'h0001
`define UAS_DIV_RST   16'h0000
`define UAS_BYTE_RST  8'h00
// Multidrop schemes
`define UAS_SCH_ALL   2'h0
`define UAS_SCH_ADDR  2'h1
`define UAS_SCH_MATCH 2'h2
`define UAS_SCH_DATA  2'h3
`endif

/* File: logic/uas_pkg.sv */
package uas_pkg;
  typedef enum logic [2:0] {
    UAS_IDLE  = 3'h0,
    UAS_START = 3'h1,
    UAS_DATA  = 3'h2,
    UAS_NINTH = 3'h3,
    UAS_STOP  = 3'h4
  } uas_phase_e;

  typedef struct packed {
    logic [15:0] div_cnt;
    logic        tick;
    logic        rxd_s1;
    logic        rxd_s2;
    logic        cts_s1;
    logic        cts_s2;
    uas_phase_e  tx_ph;
    logic [3:0]  tx_cnt;
    logic [2:0]  tx_bit;
    logic        tx_stop2;
    logic [7:0]  tx_sh;
    logic        tx_ninth;
    logic        txd;
    logic [7:0]  hold;
    logic        hold_full;
    logic        hold_flag;
    uas_phase_e  rx_ph;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_ninth;
    logic [7:0]  rx_data;
    logic        rx_ready;
    logic        rx_flag;
    logic        new_frame;
    logic        first_data;
    logic        matched;
    logic        err_fr;
    logic        err_par;
    logic        err_ovr;
    logic        err_brk;
  } uas_state_s;
endpackage : uas_pkg

/* File: verif/uas_remote.sv */
`timescale 1ns/1ns
// Remote node: sends frames on rxd_pin, captures frames from txd
module uas_remote (
  // Clock
  input  wire logic clk,
  // Line from the block, and ninth-bit enable
  input  wire logic txd,
  input  wire logic transceiver_drive,
  input  wire logic ninth_en,
  // Lines to the block
  output logic      rxd_pin,
  output logic      cts_n_pin
);
  logic [7:0] got_byte;
  logic       got_ninth;
  logic       got_stop;
  logic       got_drive;
  int         got_cnt = 0;

  initial begin
    rxd_pin   = 1'b1;
    cts_n_pin = 1'b0;
  end

  task automatic send(input logic [7:0] b, input logic nb, n_en, stp);
    logic [10:0] f;
    f = {stp, nb, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || n_en) begin
        rxd_pin = f[i];
        repeat (16) @(negedge clk);
      end
    end
    // Pulled-up idle line
    rxd_pin = 1'b1;
  endtask : send

  task automatic set_cts(input logic v);
    cts_n_pin = v;
  endtask : set_cts

  always begin
    @(negedge clk);
    if (txd === 1'b0) begin
      repeat (8) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(negedge clk);
        got_byte[i] = txd;
      end
      if (ninth_en) begin
        repeat (16) @(negedge clk);
        got_ninth = txd;
      end
      repeat (16) @(negedge clk);
      got_stop  = txd;
      got_drive = transceiver_drive;
      got_cnt++;
    end
  end
endmodule : uas_remote

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tx_enable, rx_enable, parity_on, parity_odd, two_stop, flow_ctrl_en;
  logic        multidrop_on, timer_mode, tx_wr, addr_flag_tx, rx_rd;
  logic [1:0]  multidrop_scheme;
  logic [7:0]  addr_compare, tx_data, rx_data;
  logic [15:0] baud_divider;
  logic        rx_addr_flag, rx_new_frame, tx_holding_empty, rx_byte_ready;
  logic        err_framing, err_parity, err_overrun, err_break, tx_irq, rx_irq;
  logic        timer_tick, rxd_pin, cts_n_pin, txd, transceiver_drive;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  uas_top u_dut (
    .clk               (clk),
    .rst               (rst),
    .tx_enable         (tx_enable),
    .rx_enable         (rx_enable),
    .parity_on         (parity_on),
    .parity_odd        (parity_odd),
    .two_stop          (two_stop),
    .flow_ctrl_en      (flow_ctrl_en),
    .multidrop_on      (multidrop_on),
    .multidrop_scheme  (multidrop_scheme),
    .addr_compare      (addr_compare),
    .baud_divider      (baud_divider),
    .timer_mode        (timer_mode),
    .tx_wr             (tx_wr),
    .tx_data           (tx_data),
    .addr_flag_tx      (addr_flag_tx),
    .rx_rd             (rx_rd),
    .rx_data           (rx_data),
    .rx_addr_flag      (rx_addr_flag),
    .rx_new_frame      (rx_new_frame),
    .tx_holding_empty  (tx_holding_empty),
    .rx_byte_ready     (rx_byte_ready),
    .err_framing       (err_framing),
    .err_parity        (err_parity),
    .err_overrun       (err_overrun),
    .err_break         (err_break),
    .tx_irq            (tx_irq),
    .rx_irq            (rx_irq),
    .timer_tick        (timer_tick),
    .rxd_pin           (rxd_pin),
    .cts_n_pin         (cts_n_pin),
    .txd               (txd),
    .transceiver_drive (transceiver_drive)
  );
  uas_remote u_remote (.clk(clk), .txd(txd), .transceiver_drive(transceiver_drive),
    .ninth_en(parity_on | multidrop_on), .rxd_pin(rxd_pin), .cts_n_pin(cts_n_pin));

  task summarize;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task wait_frame(input int c);
    for (int i = 0; i < 4000 && u_remote.got_cnt == c; i++) @(negedge clk);
    if (u_remote.got_cnt == c) begin
      miscompares++;
      $display("ERROR %0t frame timeout", $time);
      summarize();
    end
  endtask : wait_frame

  task wr(input logic [7:0] d);
    tx_data = d;
    tx_wr   = 1'b1;
    @(negedge clk);
    tx_wr   = 1'b0;
  endtask : wr

  task rd;
    rx_rd = 1'b1;
    @(negedge clk);
    rx_rd = 1'b0;
    @(negedge clk);
  endtask : rd

  task chk_reset;
    `CHK({txd, transceiver_drive, tx_holding_empty, tx_irq}, 4'hb)
    `CHK({rx_byte_ready, rx_irq}, 2'h0)
  endtask : chk_reset

  task tx_frame(input logic [7:0] d, input logic po, odd, mp, fl, ts);
    int c;
    c = u_remote.got_cnt;
    {parity_on, parity_odd, multidrop_on, addr_flag_tx, two_stop} = {po, odd, mp, fl, ts};
    wr(d);
    `CHK(tx_holding_empty, 1'b0)
    `CHK(tx_irq, 1'b0)
    wait_frame(c);
    `CHK(u_remote.got_byte, d)
    if (po | mp) `CHK(u_remote.got_ninth, mp ? fl : odd ^ (^d))
    `CHK({u_remote.got_stop, u_remote.got_drive, tx_holding_empty}, 3'h7)
    repeat (16) @(negedge clk);
    `CHK({txd, transceiver_drive}, {1'b1, ts})
    repeat (16) @(negedge clk);
  endtask : tx_frame

  task flow_hold;
    int c;
    c = u_remote.got_cnt;
    {parity_on, multidrop_on, two_stop, flow_ctrl_en} = 4'h1;
    u_remote.set_cts(1'b1);
    repeat (4) @(negedge clk);
    wr(8'h5a);
    repeat (60) @(negedge clk);
    `CHK({txd, tx_holding_empty}, 2'h2)
    u_remote.set_cts(1'b0);
    repeat (40) @(negedge clk);
    u_remote.set_cts(1'b1);
    wait_frame(c);
    `CHK(u_remote.got_byte, 8'h5a)
    `CHK(u_remote.got_stop, 1'b1)
    u_remote.set_cts(1'b0);
    flow_ctrl_en = 1'b0;
  endtask : flow_hold

  task rx_chk(input logic [7:0] b, input logic nb, stp, ep, ef, ek);
    u_remote.send(b, nb, parity_on | multidrop_on, stp);
    @(negedge clk);
    `CHK({err_parity, err_framing, err_break, rx_irq}, {ep, ef, ek, 1'b1})
    if (stp) `CHK(rx_data, b)
    rd();
    `CHK({rx_byte_ready, err_parity, err_framing, err_break}, 4'h0)
  endtask : rx_chk

  task rx_off;
    rx_enable = 1'b0;
    u_remote.send(8'h55, 1'b0, 1'b0, 1'b1);
    @(negedge clk);
    `CHK(rx_byte_ready, 1'b0)
    rx_enable = 1'b1;
  endtask : rx_off

  task overrun;
    u_remote.send(8'h21, 1'b0, 1'b0, 1'b1);
    u_remote.send(8'h22, 1'b0, 1'b0, 1'b1);
    @(negedge clk);
    `CHK({err_overrun, rx_data}, 9'h121)
    rd();
    `CHK(err_overrun, 1'b0)
  endtask : overrun

  task mdrop;
    {multidrop_on, multidrop_scheme, addr_compare} = {1'b1, 2'h2, 8'h5a};
    u_remote.send(8'h3c, 1'b1, 1'b1, 1'b1);
    u_remote.send(8'h44, 1'b0, 1'b1, 1'b1);
    @(negedge clk);
    `CHK(rx_byte_ready, 1'b0)
    u_remote.send(8'h5a, 1'b1, 1'b1, 1'b1);
    @(negedge clk);
    `CHK({rx_byte_ready, rx_addr_flag, rx_data}, 10'h35a)
    rd();
    u_remote.send(8'h77, 1'b0, 1'b1, 1'b1);
    @(negedge clk);
    `CHK({rx_byte_ready, rx_new_frame, rx_data}, 10'h377)
    rd();
    multidrop_scheme = 2'h3;
    u_remote.send(8'h5a, 1'b1, 1'b1, 1'b1);
    @(negedge clk);
    `CHK(rx_byte_ready, 1'b0)
    u_remote.send(8'h66, 1'b0, 1'b1, 1'b1);
    @(negedge clk);
    `CHK({rx_byte_ready, rx_new_frame, rx_data}, 10'h366)
    rd();
    multidrop_scheme = 2'h1;
    u_remote.send(8'h12, 1'b0, 1'b1, 1'b1);
    @(negedge clk);
    `CHK(rx_byte_ready, 1'b0)
    u_remote.send(8'h3c, 1'b1, 1'b1, 1'b1);
    @(negedge clk);
    `CHK({rx_byte_ready, rx_addr_flag, rx_data}, 10'h33c)
    rd();
    multidrop_on = 1'b0;
  endtask : mdrop

  task timer_run;
    int ticks;
    ticks = 0;
    {tx_enable, timer_mode, baud_divider} = {1'b0, 1'b1, 16'h0004};
    repeat (8) @(negedge clk);
    `CHK(tx_irq, 1'b0)
    repeat (40) begin
      @(negedge clk);
      ticks += timer_tick;
    end
    `CHK(ticks, 10)
    `CHK({txd, transceiver_drive, rx_byte_ready}, 3'h4)
  endtask : timer_run

  initial begin
    {tx_enable, rx_enable, parity_on, parity_odd, two_stop, flow_ctrl_en} = 6'h30;
    {multidrop_on, timer_mode, tx_wr, addr_flag_tx, rx_rd} = 5'h00;
    {multidrop_scheme, addr_compare, tx_data} = 18'h0_0000;
    baud_divider = 16'h0001;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk_reset();
    tx_frame(8'ha5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    tx_frame(8'h3c, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    tx_frame(8'h3d, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    tx_frame(8'h81, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    tx_frame(8'h42, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    flow_hold();
    rx_off();
    {parity_on, parity_odd} = 2'h2;
    rx_chk(8'hc3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    rx_chk(8'h96, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    parity_odd = 1'b1;
    rx_chk(8'h96, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    parity_on = 1'b0;
    rx_chk(8'h11, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rx_chk(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    overrun();
    mdrop();
    timer_run();
    summarize();
  end
endmodule : tb_top
